/* File: smla_ctrl.sv */
// sync modem line adapter: transmit fifo and the line logic
`timescale 1ns/1ps

// ****************************************
// fifo
// ****************************************
module smla_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_r != (AW+1)'(D));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = mem[rp_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ****************************************
// line adapter
// ****************************************
module smla_ctrl #(
  parameter logic [5:0] LINE_ADDR = 6'h00,
  parameter logic EIGHT_NO_PAR = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // setup words from the multiplexor
  input wire logic setup_valid_i,
  input wire smla_pkg::smla_word_t setup_word_i,
  // status read
  input wire logic rd_req_i,
  input wire smla_pkg::smla_word_t rd_sel_i,
  output logic rd_valid_o,
  output smla_pkg::smla_word_t rd_word_o,
  // service requests
  output logic odr_o,
  output logic idr_o,
  output logic sir_o,
  output logic lerr_o,
  output logic [1:0] lerr_code_o,
  // modem inputs
  input wire logic tx_bit_clk_i,
  input wire logic rx_bit_clk_i,
  input wire logic rxd_i,
  input wire logic cts_i,
  input wire logic carrier_i,
  input wire logic interlock_i,
  input wire logic ring_i,
  input wire logic ctl_in_i,
  // modem outputs
  output logic txd_o,
  output logic rts_o,
  output logic dtr_o,
  output logic ctl_out_o
);
  import smla_pkg::*;

  function automatic logic odd_par(input logic [6:0] d);
    odd_par = ~(^d);
  endfunction

  // parity mode: 7 data bits plus odd parity in the top bit
  function automatic logic [7:0] fmt(input logic p, input logic [7:0] d);
    fmt = p ? {odd_par(d[6:0]), d[6:0]} : d;
  endfunction

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] pin_a;
  logic [PIN_W-1:0] pin_b;
  logic [PIN_W-1:0] pin_c;
  assign pins = {ctl_in_i, ring_i, interlock_i, carrier_i, cts_i, rxd_i,
                 rx_bit_clk_i, tx_bit_clk_i};

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      pin_a <= '0;
      pin_b <= '0;
      pin_c <= '0;
    end else begin
      pin_a <= pins;
      pin_b <= pin_a;
      pin_c <= pin_b;
    end
  end

  logic tx_tick;
  logic rx_tick;
  logic cts;
  logic ctl_chg;
  assign tx_tick = pin_b[PIN_TCLK] && !pin_c[PIN_TCLK];
  assign rx_tick = pin_b[PIN_RCLK] && !pin_c[PIN_RCLK];
  assign cts = pin_b[PIN_CTS];
  assign ctl_chg = pin_b[PIN_CTLI] != pin_c[PIN_CTLI];

  // ****************************************
  // setup decode and line registers
  // ****************************************
  smla_ctl_t ctl_r;
  logic [7:0] tsc_r;
  logic [7:0] rsc_r;
  logic hit;
  logic wr_data;
  logic wr_ctl;
  logic wr_rsc;
  assign hit = setup_valid_i && (setup_word_i.addr == LINE_ADDR);
  assign wr_data = hit && (setup_word_i.sel == SEL_DATA);
  assign wr_ctl = hit && (setup_word_i.sel == SEL_CTRL);
  assign wr_rsc = hit && (setup_word_i.sel == SEL_RSC);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      ctl_r <= CTRL_RST;
      tsc_r <= SYNC_RST;
      rsc_r <= SYNC_RST;
    end else begin
      if (wr_ctl) begin
        ctl_r <= setup_word_i.payload;
        ctl_r.p <= setup_word_i.payload[2] && EIGHT_NO_PAR;
      end
      if (hit && setup_word_i.sel == SEL_TSC) begin
        tsc_r <= setup_word_i.payload;
      end
      if (wr_rsc) begin
        rsc_r <= setup_word_i.payload;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rts_o <= 1'b0;
      dtr_o <= 1'b0;
      ctl_out_o <= 1'b0;
    end else begin
      rts_o <= ctl_r.t;
      dtr_o <= ctl_r.d;
      ctl_out_o <= ctl_r.c;
    end
  end

  // ****************************************
  // transmitter
  // ****************************************
  logic f_ready;
  logic f_valid;
  logic [7:0] f_data;
  logic tx_on;
  logic tx_load;
  logic pop;
  logic uf_evt;
  logic [2:0] tx_cnt_r;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_chr;
  // data words queue here so host bursts ride out slow modem clocks
  smla_fifo #(.W(CHAR_W), .D(FIFO_D)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .in_valid_i(wr_data),
    .in_data_i(setup_word_i.payload),
    .in_ready_o(f_ready),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(pop)
  );

  assign tx_on = ctl_r.t && cts;
  assign tx_load = tx_tick && tx_on && (tx_cnt_r == '0);
  assign pop = tx_load && !ctl_r.a && f_valid;
  assign uf_evt = tx_load && !ctl_r.a && !f_valid;
  assign tx_chr = fmt(ctl_r.p, pop ? f_data : tsc_r);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      tx_cnt_r <= '0;
      tx_sh_r <= '0;
      txd_o <= 1'b1;
    end else if (tx_tick) begin
      if (!tx_on) begin
        tx_cnt_r <= '0;
        txd_o <= 1'b1;
      end else if (tx_load) begin
        txd_o <= tx_chr[0];
        tx_sh_r <= {1'b0, tx_chr[7:1]};
        tx_cnt_r <= BIT_LAST;
      end else begin
        txd_o <= tx_sh_r[0];
        tx_sh_r <= {1'b0, tx_sh_r[7:1]};
        tx_cnt_r <= tx_cnt_r - 1'b1;
      end
    end
  end

  // requests stop while full: a data word sent anyway is refused
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      odr_o <= 1'b0;
    end else begin
      odr_o <= tx_on && !ctl_r.a && f_ready;
    end
  end

  // ****************************************
  // receiver
  // ****************************************
  smla_rx_t rx_st;
  logic [7:0] rx_sh_r;
  logic [2:0] rx_cnt_r;
  logic rx_en;
  logic [7:0] sh_n;
  logic match;
  logic chr_done;
  logic deliver;
  assign rx_en = rx_tick && ctl_r.r && pin_b[PIN_CO];
  assign sh_n = {pin_b[PIN_RXD], rx_sh_r[7:1]};
  assign match = sh_n == fmt(ctl_r.p, rsc_r);
  assign chr_done = rx_en && (rx_st != RX_HUNT) && (rx_cnt_r == BIT_LAST);
  assign deliver = chr_done && (rx_st == RX_SYNC) && !(ctl_r.s && match);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rx_st <= RX_HUNT;
      rx_sh_r <= '0;
      rx_cnt_r <= '0;
    end else if (wr_rsc || !ctl_r.r || !pin_b[PIN_CO]) begin
      rx_st <= RX_HUNT;
      rx_cnt_r <= '0;
    end else if (rx_en) begin
      rx_sh_r <= sh_n;
      rx_cnt_r <= (rx_st == RX_HUNT) ? '0 : rx_cnt_r + 1'b1;
      case (rx_st)
        RX_HUNT: begin
          if (match) begin
            rx_st <= RX_ONE;
          end
        end
        RX_ONE: begin
          if (chr_done) begin
            rx_st <= match ? RX_SYNC : RX_HUNT;
          end
        end
        RX_SYNC: begin
          rx_st <= RX_SYNC;
        end
        default: begin
          rx_st <= RX_HUNT;
        end
      endcase
    end
  end

  logic rd_hit;
  logic rd_data;
  logic rd_stat;
  logic [7:0] rx_data_r;
  logic perr_r;
  logic ovf_r;
  assign rd_hit = rd_req_i && (rd_sel_i.addr == LINE_ADDR);
  assign rd_data = rd_hit && (rd_sel_i.sel == SEL_DATA);
  assign rd_stat = rd_hit && (rd_sel_i.sel == SEL_CTRL);

  // a new character in the read cycle wins over the clear
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      idr_o <= 1'b0;
      rx_data_r <= '0;
      perr_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      if (rd_data) begin
        idr_o <= 1'b0;
        perr_r <= 1'b0;
        ovf_r <= 1'b0;
      end
      if (!ctl_r.r) begin
        perr_r <= 1'b0;
        ovf_r <= 1'b0;
      end
      if (deliver) begin
        if (idr_o && !rd_data) begin
          ovf_r <= 1'b1;
        end else begin
          idr_o <= 1'b1;
          rx_data_r <= ctl_r.p ? {1'b0, sh_n[6:0]} : sh_n;
          perr_r <= ctl_r.p && (odd_par(sh_n[6:0]) != sh_n[7]);
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      lerr_o <= 1'b0;
      lerr_code_o <= 2'h0;
    end else begin
      lerr_o <= perr_r || ovf_r;
      lerr_code_o <= {ovf_r, perr_r};
    end
  end

  // ****************************************
  // status and status change
  // ****************************************
  logic uf_r;
  logic sir_set;
  logic [7:0] stat;
  assign stat = {pin_b[PIN_ILK], pin_b[PIN_CO], cts, 2'b00, pin_b[PIN_RING],
                 pin_b[PIN_CTLI], uf_r};
  assign sir_set = (uf_evt && ctl_r.i)
                 || (ctl_chg && (ctl_r.t || ctl_r.r))
                 || (pin_b[PIN_RING] && ctl_r.a);

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      uf_r <= 1'b0;
      sir_o <= 1'b0;
    end else begin
      uf_r <= uf_evt || (uf_r && !rd_stat);
      sir_o <= sir_set || (sir_o && !rd_stat);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      rd_valid_o <= 1'b0;
      rd_word_o <= '0;
    end else begin
      rd_valid_o <= rd_hit;
      rd_word_o.payload <= rd_data ? rx_data_r : (rd_stat ? stat : 8'h00);
      rd_word_o.sel <= 2'h0;
      rd_word_o.addr <= LINE_ADDR;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  property p_rsc_resync;
    wr_rsc |=> rx_st == RX_HUNT;
  endproperty
  a_rsc_resync: assert property (p_rsc_resync) else $error("sync kept after rsc write");

  property p_two_match;
    (rx_st == RX_SYNC) && ($past(rx_st) != RX_SYNC) |-> $past(chr_done && match);
  endproperty
  a_two_match: assert property (p_two_match) else $error("sync without second match");

  property p_odr;
    odr_o |-> $past(ctl_r.t && cts && !ctl_r.a);
  endproperty
  a_odr: assert property (p_odr) else $error("output request when not allowed");

  property p_ring_stop;
    ctl_r.a |=> !odr_o;
  endproperty
  a_ring_stop: assert property (p_ring_stop) else $error("data sent under accept-ring");

  property p_uf_irq;
    uf_evt && ctl_r.i |=> sir_o && uf_r;
  endproperty
  a_uf_irq: assert property (p_uf_irq) else $error("underflow not reported");

  property p_ctl_irq;
    ctl_chg && (ctl_r.t || ctl_r.r) |=> sir_o;
  endproperty
  a_ctl_irq: assert property (p_ctl_irq) else $error("control change lost");

  property p_rd_fmt;
    rd_valid_o |-> rd_word_o.sel == 2'h0 && rd_word_o.payload[4:3] == 2'h0
                   || !$past(rd_stat);
  endproperty
  a_rd_fmt: assert property (p_rd_fmt) else $error("status word format");

  property p_del_sync;
    chr_done && rx_st == RX_SYNC && ctl_r.s && match && !rd_data |=> idr_o == $past(idr_o);
  endproperty
  a_del_sync: assert property (p_del_sync) else $error("sync char passed on");

  property p_dtr;
    $rose(ctl_r.d) |=> dtr_o;
  endproperty
  a_dtr: assert property (p_dtr) else $error("dtr not driven");

  property p_ctl_wr;
    wr_ctl |=> ctl_r.t == $past(setup_word_i.payload[0]);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("control byte not loaded");

  c_sync: cover property (rx_st == RX_ONE ##[1:200] rx_st == RX_SYNC);
  c_fill: cover property (uf_evt && ctl_r.i);
  c_ovf: cover property (deliver && idr_o && !rd_data);
  c_full: cover property (!f_ready && wr_data);
endmodule

/* File: smla_pkg.sv */
// constants, field layouts and carrier types for the sync modem line adapter
// Overview of operation
// - line error code 01 parity, 10 overflow, 11 both
// - status byte i,o,s,0,0,r,c,u; interlock, carrier and clear-to-send levels never interrupt
// - underflow bit set on fill sync, not on accept-ring sync; interrupt if i
// - control-line-in change interrupts while transmit or receive
// - ring bit follows ring; interrupts when accept-ring set
// - setup word: payload 15:8, selector 7:6, address 5:0
// - selector 00 data, 01 control, 10 tsc, 11 rsc
// - short characters right-justified, upper bits zero
// - transmit sync character whenever line would underflow
// - receive sync needs two consecutive sync matches
// - delete-sync bit discards characters matching receive sync
// - new receive sync character drops current synchronisation
// - transmit bit: mode, request-to-send, requests after clear-to-send
// - receive plus carrier: hunt, two matches, then characters
// - parity bit turns 8-bit no-parity into 7 plus parity
// - terminal-ready and control-line bits drive modem outputs
// - accept-ring requests status; stops output, sends sync continuously
// - underflow interrupt bit interrupts on each fill sync
// - setup sequence loads addressed line from setup word
// - status read returns byte, zeros in 7:6, address
package smla_pkg;

  // ****************************************
  // word and field layouts
  // ****************************************
  typedef struct packed {
    logic [7:0] payload;
    logic [1:0] sel;
    logic [5:0] addr;
  } smla_word_t;

  // line control byte, bit 14 of the word is i
  typedef struct packed {
    logic s;
    logic i;
    logic c;
    logic a;
    logic d;
    logic p;
    logic r;
    logic t;
  } smla_ctl_t;

  localparam logic [1:0] SEL_DATA = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_TSC = 2'h2;
  localparam logic [1:0] SEL_RSC = 2'h3;

  // ****************************************
  // reset values and sizes
  // ****************************************
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] SYNC_RST = 8'h00;
  localparam int CHAR_W = 8;
  localparam int FIFO_D = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ****************************************
  // synchronised pin positions
  // ****************************************
  localparam int PIN_W = 8;
  localparam int PIN_TCLK = 0;
  localparam int PIN_RCLK = 1;
  localparam int PIN_RXD = 2;
  localparam int PIN_CTS = 3;
  localparam int PIN_CO = 4;
  localparam int PIN_ILK = 5;
  localparam int PIN_RING = 6;
  localparam int PIN_CTLI = 7;

  // ****************************************
  // receiver states
  // ****************************************
  typedef enum logic [2:0] {
    RX_HUNT = 3'b001,
    RX_ONE = 3'b010,
    RX_SYNC = 3'b100
  } smla_rx_t;

endpackage

/* File: smla_mux_model.sv */
// multiplexor unit model: issues setup words and status reads
`timescale 1ns/1ps
module smla_mux_model (
  // clock
  input wire logic ref_clk_i,
  // requests to the line adapter
  output logic setup_valid_o,
  output smla_pkg::smla_word_t setup_word_o,
  output logic rd_req_o,
  output smla_pkg::smla_word_t rd_sel_o,
  // answers from the line adapter
  input wire logic rd_valid_i,
  input wire smla_pkg::smla_word_t rd_word_i
);
  import smla_pkg::*;

  initial begin
    setup_valid_o = 1'b0;
    setup_word_o = '0;
    rd_req_o = 1'b0;
    rd_sel_o = '0;
  end

  // ****************************************
  // setup word: one strobe per word
  // ****************************************
  // the bus is inverted on release so a stale word never looks like a fresh one
  task automatic setup(input logic [1:0] sel, input logic [7:0] pay, input logic [5:0] addr);
    @(negedge ref_clk_i);
    setup_word_o = '{payload: pay, sel: sel, addr: addr};
    setup_valid_o = 1'b1;
    @(negedge ref_clk_i);
    setup_valid_o = 1'b0;
    setup_word_o = ~setup_word_o;
  endtask

  // ****************************************
  // status read: selector, answer one cycle later
  // ****************************************
  task automatic rd(input logic [1:0] sel, input logic [5:0] addr, output logic got,
                    output smla_word_t w);
    @(negedge ref_clk_i);
    rd_sel_o = '{payload: 8'h00, sel: sel, addr: addr};
    rd_req_o = 1'b1;
    // the answer stands for one cycle only: take it before the selector goes away
    @(negedge ref_clk_i);
    got = rd_valid_i;
    w = rd_word_i;
    rd_req_o = 1'b0;
    rd_sel_o = ~rd_sel_o;
  endtask
endmodule

/* File: smla_ctrl_tb.sv */
// self-checking bench for the sync modem line adapter
`timescale 1ns/1ps
module smla_ctrl_tb;
  import smla_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  localparam logic [5:0] LA = 6'h05;
  logic ref_clk_i, srst_i, setup_valid_i, rd_req_i, rd_valid_o, got;
  smla_word_t setup_word_i, rd_sel_i, rd_word_o, w;
  logic odr_o, idr_o, sir_o, lerr_o, txd_o, rts_o, dtr_o, ctl_out_o;
  logic [1:0] lerr_code_o;
  logic tx_bit_clk_i, rx_bit_clk_i, rxd_i, cts_i, carrier_i, interlock_i, ring_i, ctl_in_i;
  logic [31:0] seed = 32'h0219;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [7:0] transmit_sync_char, receive_sync_char, ch, exp_ch;
  logic [7:0] txq[$];

  smla_ctrl #(.LINE_ADDR(LA)) smla_ctrl_i (.ref_clk_i, .srst_i, .setup_valid_i,
    .setup_word_i, .rd_req_i, .rd_sel_i, .rd_valid_o, .rd_word_o, .odr_o, .idr_o, .sir_o,
    .lerr_o, .lerr_code_o, .tx_bit_clk_i, .rx_bit_clk_i, .rxd_i, .cts_i, .carrier_i,
    .interlock_i, .ring_i, .ctl_in_i, .txd_o, .rts_o, .dtr_o, .ctl_out_o);
  smla_mux_model smla_mux_model_i (.ref_clk_i, .setup_valid_o(setup_valid_i),
    .setup_word_o(setup_word_i), .rd_req_o(rd_req_i), .rd_sel_o(rd_sel_i),
    .rd_valid_i(rd_valid_o), .rd_word_i(rd_word_o));

  // ****************************************
  // clock, timeout, helpers
  // ****************************************
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // whole run needs about 1500 cycles
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // bit clock high and low 4 cycles each, well above the sync latency
  task automatic tx_char(output logic [7:0] c);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk_i);
      tx_bit_clk_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      tx_bit_clk_i = 1'b0;
      repeat (3) @(negedge ref_clk_i);
      c[i] = txd_o;
    end
  endtask

  task automatic rx_char(input logic [7:0] c);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk_i);
      rxd_i = c[i];
      repeat (4) @(negedge ref_clk_i);
      rx_bit_clk_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      rx_bit_clk_i = 1'b0;
    end
    idle(8);
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    srst_i = 1'b1;
    {tx_bit_clk_i, rx_bit_clk_i, cts_i, carrier_i, interlock_i, ring_i, ctl_in_i} = '0;
    rxd_i = 1'b1;
    idle(20);
    srst_i = 1'b0;
    idle(1);
    chk("reset", {txd_o, rts_o, sir_o, odr_o}, 4'h8);
    // modem levels random, nothing armed to interrupt
    ch = rnd();
    {interlock_i, carrier_i, cts_i, ring_i, ctl_in_i} = ch[4:0];
    idle(6);
    smla_mux_model_i.rd(SEL_CTRL, LA, got, w);
    chk("status", {got, w}, {1'b1, ch[4:2], 2'b00, ch[1:0], 1'b0, 2'b00, LA});
    chk("no irq", sir_o, 1'b0);
    smla_mux_model_i.rd(SEL_CTRL, LA + 6'h01, got, w);
    chk("foreign", got, 1'b0);
    // ring with accept-ring set
    ring_i = 1'b1;
    smla_mux_model_i.setup(SEL_CTRL, 8'h10, LA);
    idle(6);
    chk("ring", {sir_o, odr_o}, 2'b10);
    smla_mux_model_i.setup(SEL_CTRL, 8'h0a, LA);
    ring_i = 1'b0;
    smla_mux_model_i.rd(SEL_CTRL, LA, got, w);
    idle(2);
    chk("ring clr", sir_o, 1'b0);
    // transmit: fill sync on empty buffer
    cts_i = 1'b1;
    ctl_in_i = 1'b0;
    transmit_sync_char = rnd();
    smla_mux_model_i.setup(SEL_TSC, transmit_sync_char, LA);
    smla_mux_model_i.setup(SEL_CTRL, 8'h69, LA);
    idle(6);
    chk("modem out", {rts_o, dtr_o, ctl_out_o, odr_o}, 4'hf);
    tx_char(ch);
    chk("fill", {ch, sir_o}, {transmit_sync_char, 1'b1});
    smla_mux_model_i.rd(SEL_CTRL, LA, got, w);
    chk("uf bit", w.payload[0], 1'b1);
    idle(2);
    ctl_in_i = 1'b1;
    idle(6);
    chk("ctl in", sir_o, 1'b1);
    // fill the buffer past full with the line stalled, then drain
    for (int k = 0; k < 9; k++) begin
      ch = rnd();
      if (txq.size() < FIFO_D) txq.push_back(ch);
      smla_mux_model_i.setup(SEL_DATA, ch, LA);
    end
    idle(2);
    chk("full", odr_o, 1'b0);
    while (txq.size() > 0) begin
      tx_char(ch);
      chk("tx data", ch, txq.pop_front());
    end
    tx_char(ch);
    chk("refill", ch, transmit_sync_char);
    // parity mode: seven data bits, odd parity in the top bit
    ch = rnd();
    exp_ch = {~^ch[6:0], ch[6:0]};
    smla_mux_model_i.setup(SEL_CTRL, 8'h6d, LA);
    smla_mux_model_i.setup(SEL_DATA, ch, LA);
    tx_char(ch);
    chk("parity tx", ch, exp_ch);
    // transmit mode held until the last character is out
    smla_mux_model_i.setup(SEL_CTRL, 8'h00, LA);
    // receive: one sync is not enough, two are
    carrier_i = 1'b1;
    receive_sync_char = 8'h16;
    smla_mux_model_i.setup(SEL_RSC, receive_sync_char, LA);
    smla_mux_model_i.setup(SEL_CTRL, 8'h02, LA);
    ch = rnd();
    if (ch == receive_sync_char) ch = ~ch;
    rx_char(receive_sync_char);
    rx_char(8'h00);
    chk("one sync", idr_o, 1'b0);
    rx_char(receive_sync_char);
    rx_char(receive_sync_char);
    rx_char(ch);
    chk("rx sync", idr_o, 1'b1);
    rx_char(~ch);
    chk("overflow", {lerr_o, lerr_code_o}, 3'b110);
    smla_mux_model_i.rd(SEL_DATA, LA, got, w);
    chk("rx data", {got, w}, {1'b1, ch, 2'b00, LA});
    idle(2);
    chk("cleared", {idr_o, lerr_o}, 2'b00);
    // delete sync, then a new receive sync drops sync
    smla_mux_model_i.setup(SEL_CTRL, 8'h82, LA);
    rx_char(receive_sync_char);
    chk("sync deleted", idr_o, 1'b0);
    rx_char(ch);
    smla_mux_model_i.rd(SEL_DATA, LA, got, w);
    chk("rx data2", w.payload, ch);
    smla_mux_model_i.setup(SEL_RSC, 8'h3c, LA);
    rx_char(ch);
    chk("resync", idr_o, 1'b0);
    end_of_test();
  end
endmodule
